// ==== inc/rpm_map.svh ====
// Constants for the reset pin and mode select block: timing counts and
// reset values, one macro each.
// Assumes a 25 MHz system clock and no register bus.
//
// What this block does
// [R1] Any reset drives reset pin low ~34 cycles; power-up drives it while reset is high, then 33 more
// [R2] Record each reset cause in status bits
// [R3] External low on reset pin requests reset
// [R4] In reset, shared pin is mode select
// [R5] After reset, shared pin becomes debug line
// [R6] High mode pin at release: normal mode
// [R7] Host holds pin low: active background mode
// [R8] Debug bit time is 16 controller clocks
// [R9] Releasing party drives brief high speedup pulse; here high lasts as long as dbg_drive_high is held
// [R10] Shared pin has internal pull-up when idle
// [R11] After reset run from internal clock generator
// [R12] Mode captured once at release, held
`ifndef RPM_MAP_SVH
`define RPM_MAP_SVH

// ==========================================================================
// Timing counts
// ==========================================================================
`define RPM_RESET_DRIVE_CYCLES 6'd34
`define RPM_BIT_TIME_CYCLES    5'd16
`define RPM_SPEEDUP_CYCLES     5'd1

// ==========================================================================
// Reset cause reset value and bit positions
// ==========================================================================
`define RPM_CAUSE_RESET        4'h0
`define RPM_CAUSE_POR_BIT      0
`define RPM_CAUSE_LVD_BIT      1
`define RPM_CAUSE_PIN_BIT      2
`define RPM_CAUSE_OTHER_BIT    3

`endif

// ==== inc/rpm_pkg.sv ====
// Types shared by the reset pin and mode select block.
// Assumes rpm_map.svh defines the numeric constants.
package rpm_pkg;

    // Reset sources sampled each cycle
    typedef struct packed {
        logic power_on;                   // Power-on detector
        logic low_voltage;                // Low-voltage detector
        logic other;                      // Watchdog, illegal op and similar
    } rpm_sources_t;

    // Three-signal view of the shared pin
    typedef struct packed {
        logic out;                        // Driven level
        logic oe;                         // High while driving
        logic pull_up;                    // Internal pull-up enabled
    } rpm_pin_drive_t;

    typedef enum logic [1:0] {
        RPM_IDLE,
        RPM_DRIVE,
        RPM_WAIT_PIN
    } rpm_state_t;

endpackage

// ==== hdl/rpm_reset_mode.sv ====
// Reset pin driver, reset-cause recorder and mode select capture.
// Assumes pins are synchronised here; the debug controller owns the debug
// line after reset and hands its drive requests in on dbg_* ports.
// Every requested reset drives the reset pin low for a fixed 34 cycles; power-up drives it while reset is high and 33 cycles more.
`timescale 1ns/100ps
`include "rpm_map.svh"

module rpm_reset_mode
    import rpm_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           reset,
    input  wire rpm_sources_t   sources,
    input  wire logic           reset_pin_in,
    output logic                reset_pin_out,
    output logic                reset_pin_oe,
    input  wire logic           mode_pin_in,
    output rpm_pin_drive_t      mode_pin,
    input  wire logic           dbg_drive_low,
    input  wire logic           dbg_drive_high,
    output logic                dbg_line_in,
    output logic                dbg_bit_tick,
    output logic                chip_reset_n,
    output logic                background_mode,
    output logic                use_internal_clock,
    output logic [3:0]          reset_cause
);

    // ======================================================================
    // Pin input synchronisers
    // ======================================================================
    logic [2:0] rst_sync_q;               // Reset pin sampler chain
    logic [2:0] ms_sync_q;                // Mode pin sampler chain
    logic       rst_lvl_q;                // Filtered reset pin level
    logic       ms_lvl_q;                 // Filtered mode pin level

    // Three-stage sampling, level moves once stages two and three agree
    always_ff @(posedge sys_clk)
    begin
        rst_sync_q <= {rst_sync_q[1:0], reset_pin_in};
        ms_sync_q  <= {ms_sync_q[1:0], mode_pin_in};
        if (reset)
        begin
            // Filters start high so reset is not taken as a pin request
            rst_lvl_q <= 1'b1;
            ms_lvl_q  <= 1'b1;
        end
        else
        begin
            if (rst_sync_q[1] == rst_sync_q[2])
                rst_lvl_q <= rst_sync_q[2];
            if (ms_sync_q[1] == ms_sync_q[2])
                ms_lvl_q <= ms_sync_q[2];
        end
    end

    // ======================================================================
    // Reset sequencing
    // ======================================================================
    rpm_state_t state_q;                  // Sequencer state
    logic [5:0] drive_cnt_q;              // Low-drive cycle counter
    logic       pin_low;                  // External request seen
    logic       int_src;                  // Any internal source
    logic       start;                    // New reset begins
    logic       release_now;              // Last cycle in reset
    logic       drive_last;               // Final cycle of the low drive
    logic       pin_oe_d;                 // Next reset pin drive enable
    logic       chip_run_d;               // Next chip run level

    assign pin_low     = ~rst_lvl_q;                               // [R3]
    assign int_src     = |sources;
    // Own drive also reads back low, so pin only starts from idle
    assign start       = (state_q == RPM_IDLE) && (int_src || pin_low);
    // Chip leaves reset only once the pin is back high and sources quiet
    assign release_now = (state_q == RPM_WAIT_PIN) && !pin_low && !int_src;
    // Counter reaches the end of the fixed drive window
    assign drive_last  = (drive_cnt_q == `RPM_RESET_DRIVE_CYCLES - 6'h01);
    // Drive starts on the request edge and stops after the last count
    assign pin_oe_d    = start || ((state_q == RPM_DRIVE) && !drive_last); // [R1]
    // Run from idle unless a reset starts; leave reset on release
    assign chip_run_d  = (state_q == RPM_IDLE) ? !start : release_now;

    // Drive the pin for the fixed count, then wait for the pin to rise
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_q     <= RPM_DRIVE;
            drive_cnt_q <= 6'h00;
        end
        else
        begin
            unique case (state_q)
                RPM_IDLE:
                begin
                    // Wait for any reset request
                    if (start)
                    begin
                        state_q     <= RPM_DRIVE;                  // [R1]
                        drive_cnt_q <= 6'h00;
                    end
                end
                RPM_DRIVE:
                begin
                    // Count the fixed low drive
                    drive_cnt_q <= drive_cnt_q + 6'h01;
                    if (drive_last)
                        state_q <= RPM_WAIT_PIN;                   // [R1]
                end
                RPM_WAIT_PIN:
                begin
                    // Hold reset until the pin and sources clear
                    if (release_now)
                        state_q <= RPM_IDLE;
                end
            endcase
        end
    end

    // Registered pin drive and chip reset
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            // Power-up counts as a reset: drive at once
            reset_pin_out <= 1'b0;
            reset_pin_oe  <= 1'b1;
            chip_reset_n  <= 1'b0;
        end
        else
        begin
            // Pin is only ever pulled low, never driven high
            reset_pin_out <= 1'b0;
            reset_pin_oe  <= pin_oe_d;                             // [R1]
            chip_reset_n  <= chip_run_d;
        end
    end

    // ======================================================================
    // Reset cause
    // ======================================================================
    logic [3:0] cause_d;                  // Cause bits of a new reset
    assign cause_d = {sources.other, pin_low && !int_src,
                      sources.low_voltage, sources.power_on};

    // Cause bits latched when a reset starts; internal-source bits accumulated while in reset
    // Pin cause only counts when no internal source is active at start
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            reset_cause <= `RPM_CAUSE_RESET;
        else if (start)
            reset_cause <= cause_d;                                // [R2]
        else if (state_q != RPM_IDLE)
            reset_cause <= reset_cause | (cause_d & {4{int_src}}); // [R2]
    end

    // ======================================================================
    // Mode select and clock choice
    // ======================================================================
    // Pin level caught once on release, held until the next release
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            background_mode    <= 1'b0;
            use_internal_clock <= 1'b1;
        end
        else if (release_now)
        begin
            // Clock choice and mode are both settled at every release
            background_mode    <= !ms_lvl_q;                // [R6] [R7] [R12]
            use_internal_clock <= 1'b1;                            // [R11]
        end
    end

    // ======================================================================
    // Shared pin function
    // ======================================================================
    logic [4:0] bit_cnt_q;                // Bit-time divider
    logic       debug_fn;                 // Pin acting as debug line
    logic       bit_last;                 // Last cycle of a bit time

    assign debug_fn = (state_q == RPM_IDLE) && !start;
    // Divider wraps after the sixteenth cycle of a bit
    assign bit_last = (bit_cnt_q == `RPM_BIT_TIME_CYCLES - 5'h01);

    // Pin drive: input only in reset, debug drive afterwards
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            // Pin released, pull-up on, no ticks
            mode_pin     <= '{out: 1'b1, oe: 1'b0, pull_up: 1'b1}; // [R4]
            dbg_line_in  <= 1'b1;
            dbg_bit_tick <= 1'b0;
            bit_cnt_q    <= 5'h00;
        end
        else
        begin
            mode_pin.pull_up <= 1'b1;                              // [R10]
            if (debug_fn)                                          // [R5]
            begin
                // Low wins; high is driven for as long as dbg_drive_high is held
                mode_pin.out <= !dbg_drive_low;                    // [R9]
                mode_pin.oe  <= dbg_drive_low || dbg_drive_high;   // [R9]
                dbg_line_in  <= ms_lvl_q;
            end
            else
            begin
                // Mode select input only, debug drive ignored
                mode_pin.out <= 1'b1;                              // [R4]
                mode_pin.oe  <= 1'b0;
                dbg_line_in  <= 1'b1;
            end
            // Tick every 16 cycles while the debug line is live
            if (!debug_fn || bit_last)
                bit_cnt_q <= 5'h00;
            else
                bit_cnt_q <= bit_cnt_q + 5'h01;
            dbg_bit_tick <= debug_fn && bit_last;                  // [R8]
        end
    end

endmodule

// ==== tb/rpm_reset_mode_assertions.sv ====
// Checker for the reset pin and mode select block.
// Bound to rpm_reset_mode; sees its ports only.
`timescale 1ns/100ps
module rpm_reset_mode_chk
    import rpm_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           reset,
    input  wire rpm_sources_t   sources,
    input  wire logic           reset_pin_in,
    input  wire logic           reset_pin_oe,
    input  wire logic           mode_pin_in,
    input  wire rpm_pin_drive_t mode_pin,
    input  wire logic           dbg_drive_low,
    input  wire logic           dbg_drive_high,
    input  wire logic           dbg_bit_tick,
    input  wire logic           chip_reset_n,
    input  wire logic           background_mode,
    input  wire logic [3:0]     reset_cause
);
    // ======================================================================
    // Properties
    // ======================================================================
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_drive_len: assert property (
        $rose(reset_pin_oe) |-> ##33 reset_pin_oe ##1 !reset_pin_oe)
        else $error("drive length");
    chk_src_start: assert property (
        chip_reset_n && |sources |=> reset_pin_oe && !chip_reset_n)
        else $error("no reset start");
    chk_cause_other: assert property (
        chip_reset_n && sources.other |=> reset_cause[3])
        else $error("cause missing");
    chk_pin_req: assert property (
        chip_reset_n && !reset_pin_in |-> ##[1:5] !chip_reset_n)
        else $error("pin request lost");
    chk_mode_input: assert property (
        !chip_reset_n |-> !mode_pin.oe)
        else $error("mode pin driven in reset");
    chk_mode_pick: assert property (
        $rose(chip_reset_n) |-> background_mode == !$past(mode_pin_in, 4))
        else $error("mode wrong");
    chk_mode_hold: assert property (
        chip_reset_n && $past(chip_reset_n) |-> $stable(background_mode))
        else $error("mode changed");
    chk_dbg_drive: assert property (
        chip_reset_n && $past(chip_reset_n) |->
        mode_pin.oe == ($past(dbg_drive_low) || $past(dbg_drive_high)) &&
        (!mode_pin.oe || mode_pin.out == !$past(dbg_drive_low)))
        else $error("debug drive wrong");
    chk_bit_time: assert property (
        $past(dbg_bit_tick, 16) && $past(chip_reset_n, 16) && chip_reset_n |-> dbg_bit_tick)
        else $error("bit time");

    // Main scenarios reached
    cover property ($rose(chip_reset_n) && background_mode);
    cover property ($rose(reset_pin_oe));
    cover property (dbg_bit_tick);
    cover property (chip_reset_n && !reset_pin_in);
endmodule
bind rpm_reset_mode rpm_reset_mode_chk u_chk (.sys_clk, .reset, .sources, .reset_pin_in,
    .reset_pin_oe, .mode_pin_in, .mode_pin, .dbg_drive_low, .dbg_drive_high, .dbg_bit_tick,
    .chip_reset_n, .background_mode, .reset_cause);

// ==== tb/rpm_far_side.sv ====
// Far side: external reset switch and debug host.
// Resolves both shared pins from all drivers and pull-ups.
`timescale 1ns/100ps
module rpm_far_side
    import rpm_pkg::*;
(
    input wire logic ext_reset,
    input wire logic host_low,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire rpm_pin_drive_t mode_pin,
    output logic reset_pin_in,
    output logic mode_pin_in
);
    // Device drive, else switch to ground, else pull-up
    assign reset_pin_in = reset_pin_oe ? reset_pin_out : !ext_reset;
    // Host low wins, else device drive or speedup, else pull-up
    assign mode_pin_in = host_low ? 1'b0 :
                         mode_pin.oe ? mode_pin.out : mode_pin.pull_up;
endmodule

// ==== tb/reset_pin_and_mode_select_tb.sv ====
// Self-checking bench for the reset pin and mode select block.
// Inputs change on the falling edge of a 25 MHz clock.
`timescale 1ns/100ps
module reset_pin_and_mode_select_tb;
    import rpm_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, ext_reset = 1'b0, host_low = 1'b0;
    logic dbg_drive_low = 1'b0, dbg_drive_high = 1'b0;
    rpm_sources_t sources = '0;
    rpm_pin_drive_t mode_pin;
    logic reset_pin_in, reset_pin_out, reset_pin_oe, mode_pin_in, dbg_line_in;
    logic dbg_bit_tick, chip_reset_n, background_mode, use_internal_clock;
    logic [3:0] reset_cause;
    int fail_count = 0, checks_done = 0, n;
    always #20 sys_clk = ~sys_clk;
    rpm_reset_mode dut (.sys_clk, .reset, .sources, .reset_pin_in, .reset_pin_out,
        .reset_pin_oe, .mode_pin_in, .mode_pin, .dbg_drive_low, .dbg_drive_high, .dbg_line_in,
        .dbg_bit_tick, .chip_reset_n, .background_mode, .use_internal_clock, .reset_cause);
    rpm_far_side far (.ext_reset, .host_low, .reset_pin_out, .reset_pin_oe, .mode_pin,
        .reset_pin_in, .mode_pin_in);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Count drive cycles until the chip leaves reset
    task automatic run_seq;
        n = 0;
        for (int i = 0; i < 300 && chip_reset_n !== 1'b1; i++)
        begin
            n += (reset_pin_oe === 1'b1);
            @(negedge sys_clk);
        end
    endtask
    // One-cycle internal request, then a full sequence
    task automatic t_source(input rpm_sources_t s, input logic [3:0] exp);
        sources = s;
        @(negedge sys_clk);
        sources = '0;
        chk(8'({reset_pin_oe, reset_pin_out, chip_reset_n}), 8'h04);
        chk(8'(mode_pin.oe), 8'h00);
        run_seq;
        chk(8'(n), 8'h22);
        chk(8'(reset_cause), 8'(exp));
    endtask
    // Switch to ground on the reset pin
    task automatic t_pin;
        ext_reset = 1'b1;
        for (int i = 0; i < 10 && chip_reset_n !== 1'b0; i++) @(negedge sys_clk);
        ext_reset = 1'b0;
        run_seq;
        chk(8'(n), 8'h22);
        chk(8'(reset_cause), 8'h04);
    endtask
    // Forced background mode, then debug traffic
    task automatic t_background_debug_line;
        host_low = 1'b1;
        // Debug drive request held across reset must be ignored
        dbg_drive_low = 1'b1;
        t_source(3'b001, 4'h8);
        chk(8'(background_mode), 8'h01);
        @(negedge sys_clk);
        chk(8'({mode_pin.oe, mode_pin.out, dbg_line_in}), 8'h04);
        dbg_drive_low = 1'b0;
        host_low = 1'b0;
        repeat (20) @(negedge sys_clk);
        chk(8'(background_mode), 8'h01);
        chk(8'(dbg_line_in), 8'h01);
        dbg_drive_low = 1'b1;
        @(negedge sys_clk);
        chk(8'({mode_pin.oe, mode_pin.out, mode_pin_in}), 8'h04);
        dbg_drive_low = 1'b0;
        dbg_drive_high = 1'b1;
        @(negedge sys_clk);
        chk(8'({mode_pin.oe, mode_pin.out, mode_pin_in}), 8'h07);
        dbg_drive_high = 1'b0;
        @(negedge sys_clk);
        chk(8'({mode_pin.oe, mode_pin_in}), 8'h01);
        t_source(3'b100, 4'h1);
        chk(8'(background_mode), 8'h00);
    endtask
    // Spacing of debug bit ticks
    task automatic t_tick;
        for (int i = 0; i < 20 && dbg_bit_tick !== 1'b1; i++) @(negedge sys_clk);
        for (n = 1; n < 40; n++)
        begin
            @(negedge sys_clk);
            if (dbg_bit_tick === 1'b1)
                break;
        end
        chk(8'(n), 8'h10);
    endtask
    initial
    begin
        repeat (8) @(negedge sys_clk);
        reset = 1'b0;
        run_seq;
        chk(8'(n), 8'h22);
        chk(8'(background_mode), 8'h00);
        chk(8'({mode_pin.pull_up, use_internal_clock}), 8'h03);
        t_source(3'b010, 4'h2);
        t_pin;
        t_background_debug_line;
        t_tick;
        summarize;
    end
    // Watchdog: tests need well under 1000 cycles
    initial
    begin
        #400000;
        fail_count++;
        summarize;
    end
endmodule
